// file: dv/cache_sram_bist_control_tb.sv
`default_nettype none
// random group mixes and injected faults against the self-test controller
module cache_sram_bist_control_tb
    import cbist_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1, hwrite = 1'b0;
    logic        hreadyout, irq, memWrite, memRead;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, memWdata;
    logic [31:0] rdWay0, rdWay1;
    logic [7:0]  faultMask = 8'h00, r = 8'h3A, memAddr;
    logic [3:0]  memGroupSel, s;
    int          nMismatch = 0, samplesChecked = 0;
    always #5 clk = ~clk;
    cbist_ctrl i_cbist_ctrl (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
        .irq(irq), .memGroupSel(memGroupSel), .memAddr(memAddr),
        .memWdata(memWdata), .memWrite(memWrite), .memRead(memRead),
        .rdWay0(rdWay0), .rdWay1(rdWay1));
    cbist_mem_model i_cbist_mem_model (.clk(clk), .memGroupSel(memGroupSel),
        .memAddr(memAddr), .memWdata(memWdata), .memWrite(memWrite),
        .memRead(memRead), .faultMask(faultMask), .rdWay0(rdWay0),
        .rdWay1(rdWay1));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        nMismatch += int'(seen !== exp);
        if (seen !== exp)
            $display("CHECK FAILED at %0t seen %h expected %h", $time,
                     seen, exp);
    endtask : check
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        htrans <= CBIST_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // finish set, fail bits only for the selected groups
    function automatic logic [31:0] expStat(input logic [3:0] g,
                                            input logic [7:0] m);
        return {24'h800000, m & {{2{g[3]}}, {2{g[2]}}, {2{g[1]}}, {2{g[0]}}}};
    endfunction : expStat
    // one run: mask, enable, poll, check, clear, disable
    task automatic run(input logic [3:0] g, input logic [7:0] m,
                       input logic [1:0] k);
        logic [31:0] q;
        logic [31:0] e;
        e = expStat(g, m);
        faultMask <= m;
        bus(1'b1, CBIST_IRQ_MASK_ADDR, {30'h0, k}, q);
        bus(1'b1, CBIST_CTRL_ADDR, {16'h0, 1'b1, 3'h0, g, 8'h0}, q);
        q = 32'h0;
        while (q[31] !== 1'b1)
            bus(1'b0, CBIST_STAT_ADDR, 32'h0, q);
        check(q, e);
        bus(1'b0, CBIST_IRQ_STAT_ADDR, 32'h0, q);
        check(q, {30'h0, |e[7:0], 1'b1});
        check({31'h0, irq}, {31'h0, |({|e[7:0], 1'b1} & k)});
        bus(1'b1, CBIST_IRQ_STAT_ADDR, 32'h3, q);
        bus(1'b1, CBIST_CTRL_ADDR, {20'h0, g, 8'h0}, q);
        @(posedge clk);
        bus(1'b0, CBIST_STAT_ADDR, 32'h0, q);
        check({31'h0, q[31]}, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test groups %h faults %h done", g, m);
    endtask : run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    // hang guard, far beyond nine full runs
    initial
    begin
        repeat (80000) @(posedge clk);
        nMismatch++;
        report_and_stop();
    end
    // reset, read-only and unmapped places, abort, then group mixes
    initial
    begin
        logic [31:0] q;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b1, CBIST_STAT_ADDR, 32'hFFFF_FFFF, q);
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, CBIST_CTRL_ADDR + 32'(4 * i), 32'h0, q);
            check(q, 32'h0);
        end
        $display("test reset values done");
        bus(1'b1, CBIST_CTRL_ADDR, 32'h0000_8F00, q);
        repeat (50) @(posedge clk);
        bus(1'b1, CBIST_CTRL_ADDR, 32'h0000_0F00, q);
        @(posedge clk);
        bus(1'b0, CBIST_STAT_ADDR, 32'h0, q);
        check({31'h0, q[31]}, 32'h0);
        check({31'h0, memWrite | memRead}, 32'h0);
        $display("test abort done");
        for (int i = 0; i < 9; i++)
        begin
            r = lfsr(r);
            s = r[3:0];
            r = lfsr(r);
            run(i < 4 ? 4'h1 << i : i == 4 ? 4'hF : i == 5 ? 4'h0 : s, r,
                2'(i));
        end
        report_and_stop();
    end
endmodule : cache_sram_bist_control_tb
`default_nettype wire

// file: dv/cbist_ctrl_chk.sv
`default_nettype none
// bus and test port checks on the controller
module cbist_ctrl_chk
    import cbist_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic [1:0]  hresp,
    // array test port
    input wire logic [3:0]  memGroupSel,
    input wire logic [31:0] memWdata,
    input wire logic        memWrite,
    input wire logic        memRead
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic acc = hsel && hreadyout && htrans == CBIST_HTRANS_NONSEQ;
    logic        rdQ;  // read data phase
    logic        wrQ;  // write data phase
    logic [31:0] aQ;   // its address
    // track the data phase that follows each accepted address
    always_ff @(posedge clk)
    begin
        rdQ <= !rst && acc && !hwrite;
        wrQ <= !rst && acc && hwrite;
        aQ  <= haddr;
    end
    a_ready_high: assert property (
        hreadyout) else $error("bus ready low");
    a_resp_okay: assert property (
        hresp == CBIST_HRESP_OKAY) else $error("bus error response");
    a_group_onehot: assert property (
        $onehot0(memGroupSel)) else $error("two groups at once");
    a_strobe_group: assert property (
        memWrite || memRead |-> memGroupSel != 4'h0)
        else $error("strobe with no group");
    a_write_pattern: assert property (
        memWrite |-> memWdata == CBIST_PATTERN || memWdata == ~CBIST_PATTERN)
        else $error("bad array write data");
    a_abort_stops: assert property (
        wrQ && aQ == CBIST_CTRL_ADDR && !hwdata[CBIST_CTRL_EN_BIT] |=> ##1
        !memWrite && !memRead) else $error("strobe after abort");
    a_rdata_hold: assert property (
        !$stable(hrdata) |-> $past(acc && !hwrite))
        else $error("read data moved without a read");
    a_stat_reserved: assert property (
        rdQ && aQ == CBIST_STAT_ADDR |-> hrdata[30:8] == 23'h0)
        else $error("reserved status bits set");
    a_unmapped_zero: assert property (
        rdQ && aQ[31:4] != 28'hFFF6000 |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : cbist_ctrl_chk
bind cbist_ctrl cbist_ctrl_chk i_cbist_ctrl_chk (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp),
    .memGroupSel(memGroupSel), .memWdata(memWdata),
    .memWrite(memWrite), .memRead(memRead));
`default_nettype wire

// file: dv/cbist_mem_model.sv
`default_nettype none
// cache arrays: both ways of a group, read data one cycle after the strobe
module cbist_mem_model
    import cbist_pkg::*;
(
    // test port, faultMask bit 2g+w corrupts group g way w
    input  wire logic        clk,
    input  wire logic [3:0]  memGroupSel,
    input  wire logic [7:0]  memAddr,
    input  wire logic [31:0] memWdata,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    input  wire logic [7:0]  faultMask,
    // read data of both ways
    output var logic [31:0]  rdWay0 = 32'h0,
    output var logic [31:0]  rdWay1 = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [8][256];  // row 2g+w holds group g way w
    // one-hot select to group number
    wire logic [1:0] g = {memGroupSel[3] | memGroupSel[2],
                          memGroupSel[3] | memGroupSel[1]};
    // same word to both ways; outside reads the lines toggle
    always_ff @(posedge clk)
    begin
        if (memWrite)
        begin
            mem[{g, 1'b0}][memAddr] <= memWdata;
            mem[{g, 1'b1}][memAddr] <= memWdata;
        end
        rdWay0 <= memRead
                  ? mem[{g, 1'b0}][memAddr] ^ {32{faultMask[{g, 1'b0}]}}
                  : ~rdWay0;
        rdWay1 <= memRead
                  ? mem[{g, 1'b1}][memAddr] ^ {32{faultMask[{g, 1'b1}]}}
                  : ~rdWay1;
    end
endmodule : cbist_mem_model
`default_nettype wire

// file: rtl/cbist_ctrl.sv
// What this block does
// - enable bit starts testing every selected group
// - bit 11 selects data tag group
// - bit 10 selects instruction tag group
// - bit 9 selects data cache group
// - bit 8 selects instruction cache group
// - any mix of four groups per run
// - finish bit 31 rises when run ends
// - fail flags meaningful only after finish
// - status bits 7..4 report tag way failures
// - status bits 3..0 report data way failures
//
// Added by the designer: the AHB-Lite slave port.
`default_nettype none
module cbist_ctrl
    import cbist_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // bus slave, address and data phases
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic [1:0]                       hresp,
    output logic [31:0]                      hrdata,
    // interrupt request
    output logic                             irq,
    // group select toward the arrays, one hot
    output logic [CBIST_NUM_GROUPS-1:0]      memGroupSel,
    // shared test port toward both ways of the selected group
    output logic [CBIST_MEM_ADDR_W-1:0]      memAddr,
    output logic [CBIST_MEM_DATA_W-1:0]      memWdata,
    output logic                             memWrite,
    output logic                             memRead,
    input  wire logic [CBIST_MEM_DATA_W-1:0] rdWay0,
    input  wire logic [CBIST_MEM_DATA_W-1:0] rdWay1
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic                        selEnable;   // self-test enable bit
    logic [CBIST_NUM_GROUPS-1:0] selGroups;   // group select bits
    logic                        finished;    // run complete flag
    logic [CBIST_NUM_FAILS-1:0]  failFlags;   // per-way fail flags
    logic [CBIST_IRQ_W-1:0]      irqStatus;   // sticky event bits
    logic [CBIST_IRQ_W-1:0]      irqMask;     // event enables
    cbist_seq_t                  seqState;    // sequencer state
    cbist_seq_t                  next_seqState;
    logic [1:0]                  grp;         // group under test
    logic                        marchStart;  // one-cycle launch
    logic                        wrPending;   // write data phase due
    logic [31:0]                 wrAddr;      // address of that write

    // ------------------------------------------------------------
    // engine hand-shake
    // ------------------------------------------------------------
    logic                        marchDone;   // engine finished group
    logic [CBIST_NUM_WAYS-1:0]   marchFail;   // fails of both ways

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a transfer is taken when selected, non-sequential and the bus is ready
    wire addrPhase = hsel && hready && (htrans == CBIST_HTRANS_NONSEQ);
    wire rdTake    = addrPhase && !hwrite;
    wire wrTake    = addrPhase && hwrite;

    // register hits during the write data phase
    wire wrCtrl    = wrPending && (wrAddr == CBIST_CTRL_ADDR);
    wire wrIrqStat = wrPending && (wrAddr == CBIST_IRQ_STAT_ADDR);
    wire wrIrqMask = wrPending && (wrAddr == CBIST_IRQ_MASK_ADDR);

    // register images as read back; reserved bits are zero
    wire [31:0] ctrlImage =
        (32'(selEnable) << CBIST_CTRL_EN_BIT) |
        (32'(selGroups) << CBIST_CTRL_SEL_LSB);
    wire [31:0] statImage =
        (32'(finished) << CBIST_STAT_FINISH_BIT) |
        (32'(failFlags) << CBIST_STAT_FAIL_LSB);
    wire [31:0] irqStatImage = 32'(irqStatus);
    wire [31:0] irqMaskImage = 32'(irqMask);

    // read mux on the address phase; unmapped addresses read zero
    wire [31:0] rdMux =
        (haddr == CBIST_CTRL_ADDR)     ? ctrlImage    :
        (haddr == CBIST_STAT_ADDR)     ? statImage    :
        (haddr == CBIST_IRQ_STAT_ADDR) ? irqStatImage :
        (haddr == CBIST_IRQ_MASK_ADDR) ? irqMaskImage :
        32'h0000_0000;

    // ------------------------------------------------------------
    // control bits as written
    // ------------------------------------------------------------
    wire                        wrEnable = hwdata[CBIST_CTRL_EN_BIT];
    wire [CBIST_NUM_GROUPS-1:0] wrGroups =
        hwdata[CBIST_CTRL_SEL_LSB +: CBIST_NUM_GROUPS];

    // ------------------------------------------------------------
    // sequencer conditions
    // ------------------------------------------------------------
    // a run begins once enable is set and no result is standing
    wire runStart  = selEnable && !finished
                     && (seqState == SEQ_IDLE);
    // dropping enable stops the run and the engine
    wire runAbort  = !selEnable;
    // the group under test is tested only if its bit is set
    wire grpChosen = selGroups[grp];
    wire grpLast   = (grp == 2'h3);
    wire recordNow = (seqState == SEQ_WAIT) && marchDone;
    wire runEnd    = (seqState == SEQ_FINISH) && selEnable;

    // fail flags gathered from the engine per group
    logic [CBIST_NUM_FAILS-1:0] next_failFlags;

    // each group owns two adjacent bits: way 0 low, way 1 high
    genvar g;
    generate
        for (g = 0; g < CBIST_NUM_GROUPS; g = g + 1)
        begin : gFail
            // a new run clears every flag, so unselected stay zero
            assign next_failFlags[2*g +: 2] =
                runStart ? 2'h0 :
                (recordNow && grp == 2'(g)) ? marchFail :
                failFlags[2*g +: 2];
        end
    endgenerate

    // events: a finished run, and a finished run with any failure
    wire [CBIST_IRQ_W-1:0] irqEvent;
    assign irqEvent[CBIST_IRQ_DONE_BIT] = runEnd;
    assign irqEvent[CBIST_IRQ_FAIL_BIT] = runEnd && (|failFlags);

    // write-one clears, but a same-cycle event wins over the clear
    wire [CBIST_IRQ_W-1:0] irqClear =
        wrIrqStat ? hwdata[CBIST_IRQ_W-1:0] : '0;
    wire [CBIST_IRQ_W-1:0] next_irqStatus =
        (irqStatus & ~irqClear) | irqEvent;
    wire [CBIST_IRQ_W-1:0] next_irqMask =
        wrIrqMask ? hwdata[CBIST_IRQ_W-1:0] : irqMask;

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    // walks groups 0 to 3, runs the engine on chosen ones
    always_comb
    begin
        next_seqState = seqState;
        case (seqState)
            SEQ_IDLE:
            begin
                // start scanning from group 0
                if (runStart)
                    next_seqState = SEQ_NEXT;
            end
            SEQ_NEXT:
            begin
                // launch a chosen group, skip an unchosen one
                if (grpChosen)
                    next_seqState = SEQ_LAUNCH;
                else if (grpLast)
                    next_seqState = SEQ_FINISH;
            end
            SEQ_LAUNCH:
            begin
                // the engine has seen its start pulse
                next_seqState = SEQ_WAIT;
            end
            SEQ_WAIT:
            begin
                // result recorded, move on or finish
                if (marchDone)
                    next_seqState = grpLast ? SEQ_FINISH : SEQ_NEXT;
            end
            SEQ_FINISH:
            begin
                // raise the finish flag and rest
                next_seqState = SEQ_IDLE;
            end
            default:
            begin
                // stray code returns to rest
                next_seqState = SEQ_IDLE;
            end
        endcase
        // abort wins in every state
        if (runAbort)
            next_seqState = SEQ_IDLE;
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    // state and group pointer
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seqState <= SEQ_IDLE;
            grp      <= 2'h0;
        end
        else
        begin
            seqState <= next_seqState;
            // pointer resets at start, steps past each group
            if (runStart)
                grp <= 2'h0;
            else if ((seqState == SEQ_NEXT && !grpChosen) || recordNow)
                grp <= grpLast ? grp : grp + 2'h1;
        end
    end

    // launch pulse and one-hot select toward the arrays
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            marchStart  <= 1'b0;
            memGroupSel <= '0;
        end
        else
        begin
            marchStart  <= (next_seqState == SEQ_LAUNCH);
            // select stands while the group is under test
            if (next_seqState == SEQ_LAUNCH || next_seqState == SEQ_WAIT)
                memGroupSel <= 4'(4'h1 << grp);
            else
                memGroupSel <= '0;
        end
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    // finish flag and fail flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            finished  <= CBIST_STAT_RESET[CBIST_STAT_FINISH_BIT];
            failFlags <= CBIST_STAT_RESET[CBIST_NUM_FAILS-1:0];
        end
        else
        begin
            // finish rises at run end, drops with enable
            if (runAbort)
                finished <= 1'b0;
            else if (runEnd)
                finished <= 1'b1;
            // flags keep their last values until a new run
            failFlags <= next_failFlags;
        end
    end

    // ------------------------------------------------------------
    // control and interrupt registers
    // ------------------------------------------------------------
    // software-written control and mask, sticky status
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            selEnable <= CBIST_CTRL_RESET[CBIST_CTRL_EN_BIT];
            selGroups <= CBIST_CTRL_RESET[CBIST_CTRL_SEL_LSB +:
                                          CBIST_NUM_GROUPS];
            irqStatus <= CBIST_IRQ_RESET;
            irqMask   <= CBIST_IRQ_RESET;
        end
        else
        begin
            // control write takes enable and all selects together
            if (wrCtrl)
            begin
                selEnable <= wrEnable;
                selGroups <= wrGroups;
            end
            irqStatus <= next_irqStatus;
            irqMask   <= next_irqMask;
        end
    end

    // interrupt level from the values the registers are taking
    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(next_irqStatus & next_irqMask);
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    // zero wait states; writes land in the data phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp     <= CBIST_HRESP_OKAY;
            hrdata    <= 32'h0000_0000;
            wrPending <= 1'b0;
            wrAddr    <= 32'h0000_0000;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= CBIST_HRESP_OKAY;
            // read data captured on the address phase
            if (rdTake)
                hrdata <= rdMux;
            // remember a write for its data phase
            wrPending <= wrTake;
            if (wrTake)
                wrAddr <= haddr;
        end
    end

    // ------------------------------------------------------------
    // march engine for both ways of the selected group
    // ------------------------------------------------------------
    cbist_march u_march (
        .clk      (clk),
        .rst      (rst),
        .start    (marchStart),
        .abort    (runAbort),
        .done     (marchDone),
        .failWay  (marchFail),
        .memAddr  (memAddr),
        .memWdata (memWdata),
        .memWrite (memWrite),
        .memRead  (memRead),
        .rdWay0   (rdWay0),
        .rdWay1   (rdWay1)
    );

    // hsize is not checked; every transfer is taken as a full word
    wire unusedSize = ^hsize;

endmodule : cbist_ctrl
`default_nettype wire

// file: rtl/cbist_march.sv
`default_nettype none
// march engine: writes, reads back and compares both ways of one group
module cbist_march
    import cbist_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    // control from the sequencer
    input  wire logic                        start,
    input  wire logic                        abort,
    output logic                             done,
    output logic [CBIST_NUM_WAYS-1:0]        failWay,
    // test port to the arrays
    output logic [CBIST_MEM_ADDR_W-1:0]      memAddr,
    output logic [CBIST_MEM_DATA_W-1:0]      memWdata,
    output logic                             memWrite,
    output logic                             memRead,
    input  wire logic [CBIST_MEM_DATA_W-1:0] rdWay0,
    input  wire logic [CBIST_MEM_DATA_W-1:0] rdWay1
);

    cbist_mar_t                  state;      // current march step
    cbist_mar_t                  next_state; // step after this cycle
    logic [CBIST_MEM_ADDR_W-1:0] addr;       // address counter
    logic [CBIST_MEM_DATA_W-1:0] expIssue;   // expected data of this read
    logic [CBIST_MEM_DATA_W-1:0] expCmp;     // expected data now returning
    logic                        cmpValid;   // read data valid this cycle

    // ascending phases end at the top, descending at zero
    wire addrTop  = (addr == CBIST_MEM_ADDR_MAX);
    wire addrZero = (addr == '0);
    wire drainEnd = (addr == CBIST_DRAIN_CYC);
    wire issueWr  = (state == MAR_WR0) || (state == MAR_WR1);
    wire issueRd  = (state == MAR_RD0) || (state == MAR_RD1);
    wire [CBIST_MEM_DATA_W-1:0] issueData =
        (state == MAR_WR0) ? CBIST_PATTERN : ~CBIST_PATTERN;
    wire [CBIST_MEM_DATA_W-1:0] issueExp =
        (state == MAR_RD0) ? CBIST_PATTERN : ~CBIST_PATTERN;
    wire miss0 = cmpValid && (rdWay0 != expCmp);
    wire miss1 = cmpValid && (rdWay1 != expCmp);

    // step order: write all, read-write up, read down, drain
    always_comb
    begin
        next_state = state;
        case (state)
            MAR_IDLE:  if (start) next_state = MAR_WR0;
            MAR_WR0:   if (addrTop) next_state = MAR_RD0;
            MAR_RD0:   next_state = MAR_WR1;
            MAR_WR1:   next_state = addrTop ? MAR_RD1 : MAR_RD0;
            MAR_RD1:   if (addrZero) next_state = MAR_DRAIN;
            MAR_DRAIN: if (drainEnd) next_state = MAR_IDLE;
            default:   next_state = MAR_IDLE;
        endcase
        if (abort)
            next_state = MAR_IDLE;
    end

    // state, address and drain counter
    always_ff @(posedge clk)
    begin
        if (rst || abort || (state == MAR_IDLE))
        begin
            state <= rst ? MAR_IDLE : next_state;
            addr  <= '0;
        end
        else
        begin
            state <= next_state;
            // counter steps after a write going up, after a read going down
            if ((state == MAR_WR0 || state == MAR_WR1) && !addrTop)
                addr <= addr + 8'h01;
            else if (state == MAR_WR0 || state == MAR_WR1)
                addr <= addrTop && state == MAR_WR0 ? '0 : addr;
            else if (state == MAR_RD1)
                addr <= addrZero ? '0 : addr - 8'h01;
            else if (state == MAR_DRAIN)
                addr <= addr + 8'h01;
        end
    end

    // registered test port and compare pipeline
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            memAddr  <= '0;
            memWdata <= '0;
            memWrite <= 1'b0;
            memRead  <= 1'b0;
            expIssue <= '0;
            expCmp   <= '0;
            cmpValid <= 1'b0;
            failWay  <= '0;
            done     <= 1'b0;
        end
        else
        begin
            memAddr  <= addr;
            memWdata <= issueData;
            memWrite <= issueWr && !abort;
            memRead  <= issueRd && !abort;
            expIssue <= issueExp;
            expCmp   <= expIssue;
            cmpValid <= memRead && !abort;
            // a mismatch marks its way until the next start
            failWay  <= start ? '0 : (failWay | {miss1, miss0});
            done     <= (state == MAR_DRAIN) && drainEnd && !abort;
        end
    end

endmodule : cbist_march
`default_nettype wire

// file: rtl/cbist_pkg.sv
`default_nettype none
// shared constants for the cache memory self-test controller
package cbist_pkg;

    // register byte addresses on the bus
    localparam logic [31:0] CBIST_CTRL_ADDR     = 32'hFFF6_0000;
    localparam logic [31:0] CBIST_STAT_ADDR     = 32'hFFF6_0004;
    localparam logic [31:0] CBIST_IRQ_STAT_ADDR = 32'hFFF6_0008;
    localparam logic [31:0] CBIST_IRQ_MASK_ADDR = 32'hFFF6_000C;

    // reset values
    localparam logic [31:0] CBIST_CTRL_RESET    = 32'h0000_0000;
    localparam logic [31:0] CBIST_STAT_RESET    = 32'h0000_0000;
    localparam logic [1:0]  CBIST_IRQ_RESET     = 2'h0;

    // control register fields
    localparam int CBIST_CTRL_EN_BIT  = 15;
    localparam int CBIST_CTRL_SEL_LSB = 8;
    localparam int CBIST_NUM_GROUPS   = 4;
    localparam int CBIST_NUM_WAYS     = 2;
    localparam int CBIST_NUM_FAILS    = 8;

    // status register fields
    localparam int CBIST_STAT_FINISH_BIT = 31;
    localparam int CBIST_STAT_FAIL_LSB   = 0;

    // interrupt status and mask fields
    localparam int CBIST_IRQ_W        = 2;
    localparam int CBIST_IRQ_DONE_BIT = 0;
    localparam int CBIST_IRQ_FAIL_BIT = 1;

    // test port geometry of the cache arrays
    localparam int CBIST_MEM_ADDR_W = 8;
    localparam int CBIST_MEM_DATA_W = 32;
    localparam logic [CBIST_MEM_ADDR_W-1:0] CBIST_MEM_ADDR_MAX = 8'hFF;
    localparam logic [CBIST_MEM_DATA_W-1:0] CBIST_PATTERN = 32'h5555_5555;

    // last drain count; three cycles spent draining the read pipeline before done
    localparam logic [CBIST_MEM_ADDR_W-1:0] CBIST_DRAIN_CYC = 8'h02;

    // bus transfer type and response
    localparam logic [1:0] CBIST_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] CBIST_HRESP_OKAY    = 2'h0;

    // sequencer states, gray from idle through wait to finish, not on wait to next, next to finish or finish to idle
    typedef enum logic [2:0] {
        SEQ_IDLE   = 3'h0,
        SEQ_NEXT   = 3'h1,
        SEQ_LAUNCH = 3'h3,
        SEQ_WAIT   = 3'h2,
        SEQ_FINISH = 3'h6
    } cbist_seq_t;

    // march engine states, gray along the usual path except the drain to idle step
    typedef enum logic [2:0] {
        MAR_IDLE  = 3'h0,
        MAR_WR0   = 3'h1,
        MAR_RD0   = 3'h3,
        MAR_WR1   = 3'h2,
        MAR_RD1   = 3'h6,
        MAR_DRAIN = 3'h7
    } cbist_mar_t;

endpackage : cbist_pkg
`default_nettype wire
